// File: logic/sgf_pkg.sv
// shared constants and carrier types for the bridge converter control block
// assumes a single 250 MHz clock; times are turned into cycle counts here
package sgf_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int US_NS = 1000;
    localparam int US_CYC = US_NS / CLK_PERIOD_NS;
    localparam int CONV_SHORT_US = 50;
    localparam int CONV_LONG_US = 100;
    localparam int CONV_SHORT_CYC = CONV_SHORT_US * US_NS / CLK_PERIOD_NS;
    localparam int CONV_LONG_CYC = CONV_LONG_US * US_NS / CLK_PERIOD_NS;
    localparam int MIN_BUS_US = 250;
    localparam int SLOTS = 10;
    localparam int MIN_SLOTS = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int FIR_FILL = 16;
    localparam logic [15:0] SLOT_INVALID = 16'h8000;
    localparam logic [23:0] VALUE_INVALID = 24'h800000;
    localparam logic [3:0] IIR_MAX = 4'h8;
    localparam logic [3:0] CODE_MAX = 4'hd;
    localparam logic [15:0] RATE_FINE = 16'h0001;
    localparam logic [7:0] CYC_LONG = 8'h01;
    localparam int ST_INVALID = 0;
    localparam int ST_OPEN = 1;
    localparam int ST_NOSYNC = 2;
    localparam int ST_MOD_SUP = 3;
    localparam int ST_EXC_SUP = 4;
    localparam int ST_FIR_BUSY = 5;
    localparam logic [7:0] HEALTH_RST = 8'h00;
    localparam logic [31:0] STAMP_RST = 32'h00000000;

    typedef enum logic {SGF_MULTI = 1'b0, SGF_EXT = 1'b1} sgf_model_t;

    typedef struct packed {
        logic [7:0] filter_and_range_config;
        logic [15:0] rate_mode_select;
        logic [7:0] coded_output_rate;
        logic [15:0] fine_step_output_rate;
        logic [7:0] converter_cycle_select;
    } sgf_cfg_t;

    typedef struct packed {
        logic open;
        logic invalid;
        logic [23:0] raw;
    } sgf_sample_t;
endpackage

// File: logic/sgf_fifo.sv
// small synchronous fifo between the converter and the sample store
// assumes one clock; in_ready is a flop, out_valid follows the fill count
`timescale 1ns/1ps
`default_nettype none
module sgf_fifo #(
    parameter int W = 26,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic rdy_q, rdy_d, push, pop;

    // pointer and fill bookkeeping; ready is precomputed so it is glitch free
    always_comb begin
        push = in_valid && rdy_q;
        pop = out_ready && (cnt_q != '0);
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        rdy_d = cnt_d != (AW+1)'(D);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    // storage has no reset; only written slots are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    assign in_ready = rdy_q;
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rp_q];
endmodule
`default_nettype wire

// File: logic/sgf_mem.sv
// two-bank store for multisample results, read data from a register
// assumes one writer and one reader in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module sgf_mem #(
    parameter int W = 16,
    parameter int N = 32
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [$clog2(N)-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [$clog2(N)-1:0] raddr,
    output logic [W-1:0] rdata_q
);
    logic [W-1:0] mem_q [N];

    // read before write (a same-cycle write is not seen), read registered one cycle later
    always_ff @(posedge clk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
        rdata_q <= mem_q[raddr];
    end
endmodule
`default_nettype wire

// File: logic/sgf_ctrl.sv
// register-level control and status for a single bridge converter channel
// assumes the cyclic bus exchange presents config as levels and marks
// each bus cycle with a one-cycle bus_cycle_start pulse
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - converter not lockable to bus cycle sets the sync status bit.
// - sync indication sits in status bit 2; 0 means synchronous.
// - each multisample slot holds a 16-bit signed sample.
// - three to ten samples per bus cycle, set by bus and converter cycles.
// - surplus conversions drop the oldest; only the latest are returned.
// - bus cycle not a multiple of converter cycle fills slots with 0x8000.
// - filter bits 0-3: 0000 bypasses IIR, 0001-1000 pick levels 1-8.
// - filter bits 4-6 pick range; master keeps bit 7 low.
// - rate mode 0 (reset) uses coded rate, 1 uses fine-step rate.
// - coded rate 0000-1101 maps to 2.5 up to 7500 samples per second.
// - coded rate 1110 or 1111 reports an invalid input value.
// - fine-step N sets N times 0.1 Hz; zero disables FIR.
// - supply fault gives invalid value and clears active filter history.
// - status bit 0 flags invalid value, bit 1 flags open bridge.
// - status bit 3 shows module supply fault.
// - status bit 4 shows excitation supply fault.
// - status bit 5 high until FIR filled; bits 2, 6, 7 reserved.
// - 32-bit microsecond timestamp captured at each conversion completion.
// - multisample update interval equals converter cycle, 50 or 100 us.
module sgf_ctrl
    import sgf_pkg::*;
#(
    parameter int SHORT_CYC = CONV_SHORT_CYC,
    parameter int LONG_CYC = CONV_LONG_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic bus_cycle_start,
    input wire sgf_pkg::sgf_model_t model_sel,
    input wire sgf_pkg::sgf_cfg_t cfg,
    input wire sgf_pkg::sgf_sample_t conv_sample,
    input wire logic conv_valid,
    output logic conv_ready,
    input wire logic module_supply_fault,
    input wire logic excite_supply_fault,
    input wire logic [3:0] slot_sel,
    output logic [15:0] slot_data_q,
    output logic [7:0] health_q,
    output logic [31:0] stamp_q,
    output logic conv_start_q,
    output logic [3:0] iir_level_q,
    output logic [2:0] range_q,
    output logic fir_en_q,
    output logic [16:0] fir_rate_q,
    output logic filter_clear_q,
    output logic [23:0] ext_value_q
);
    import sgf_pkg::*;

    // coded rate in tenths of a hertz
    function automatic logic [16:0] coded_tenths(input logic [3:0] c);
        case (c)
            4'h0: coded_tenths = 17'd25;
            4'h1: coded_tenths = 17'd50;
            4'h2: coded_tenths = 17'd100;
            4'h3: coded_tenths = 17'd150;
            4'h4: coded_tenths = 17'd250;
            4'h5: coded_tenths = 17'd300;
            4'h6: coded_tenths = 17'd500;
            4'h7: coded_tenths = 17'd600;
            4'h8: coded_tenths = 17'd1000;
            4'h9: coded_tenths = 17'd5000;
            4'ha: coded_tenths = 17'd10000;
            4'hb: coded_tenths = 17'd20000;
            4'hc: coded_tenths = 17'd37500;
            4'hd: coded_tenths = 17'd75000;
            default: coded_tenths = 17'd0;
        endcase
    endfunction

    logic multi, fine, rate_bad, supply_bad, fir_on;
    logic [7:0] us_div_q, us_div_d;
    logic [31:0] us_cnt_q, us_cnt_d, stamp_d;
    logic [14:0] conv_cnt_q, conv_cnt_d, conv_last;
    logic conv_start_d, nosync_q, nosync_d;
    sgf_sample_t ff_out;
    logic ff_valid, ff_ready, push, pop;

    assign multi = model_sel == SGF_MULTI;
    assign fine = cfg.rate_mode_select == RATE_FINE;
    assign rate_bad = !fine && (cfg.coded_output_rate[3:0] > CODE_MAX);
    assign supply_bad = module_supply_fault || excite_supply_fault;
    assign fir_on = !fine || (cfg.fine_step_output_rate != 16'h0000);
    // reserved cycle codes fall back to the short cycle
    assign conv_last = (cfg.converter_cycle_select == CYC_LONG) ?
        15'(LONG_CYC - 1) : 15'(SHORT_CYC - 1);
    // a sample is taken when the fifo accepts it, not when the store drains it
    assign push = conv_valid && conv_ready;
    // drain stalls in the snapshot cycle so no sample straddles two banks
    assign ff_ready = !bus_cycle_start;
    assign pop = ff_valid && ff_ready;

    sgf_fifo #(.W($bits(sgf_sample_t)), .D(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_data(conv_sample),
        .in_valid(conv_valid),
        .in_ready(conv_ready),
        .out_data(ff_out),
        .out_valid(ff_valid),
        .out_ready(ff_ready)
    );

    // timing: microsecond clock, converter pacing and bus lock check
    always_comb begin
        us_div_d = (us_div_q == 8'(US_CYC - 1)) ? 8'h00 : us_div_q + 8'h01;
        us_cnt_d = (us_div_q == 8'(US_CYC - 1)) ? us_cnt_q + 32'h1 : us_cnt_q;
        stamp_d = push ? us_cnt_q : stamp_q;
        conv_cnt_d = (conv_cnt_q >= conv_last) ? 15'h0 : conv_cnt_q + 15'h1;
        nosync_d = nosync_q;
        if (bus_cycle_start && multi) begin
            // a whole multiple of the converter cycle lands back on phase 0
            nosync_d = conv_cnt_q != 15'h0;
            conv_cnt_d = 15'h1;
        end
        if (!multi) begin
            nosync_d = 1'b0;
        end
        conv_start_d = multi && (conv_cnt_d == 15'h0);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            us_div_q <= 8'h00;
            us_cnt_q <= STAMP_RST;
            stamp_q <= STAMP_RST;
            conv_cnt_q <= 15'h0;
            nosync_q <= 1'b0;
            conv_start_q <= 1'b0;
        end else begin
            us_div_q <= us_div_d;
            us_cnt_q <= us_cnt_d;
            stamp_q <= stamp_d;
            conv_cnt_q <= conv_cnt_d;
            nosync_q <= nosync_d;
            conv_start_q <= conv_start_d;
        end
    end

    // capture: ring of ten per bank, bank flips at every bus cycle
    logic bank_q, bank_d, rd_bank_q, rd_bank_d;
    logic [3:0] wp_q, wp_d, rd_start_q, rd_start_d, rd_cnt_q, rd_cnt_d;
    logic [4:0] n_q, n_d, sum;
    logic open_acc_q, open_acc_d, inv_acc_q, inv_acc_d;
    logic open_q, open_d, inv_q, inv_d, mem_we;
    logic [4:0] fill_q, fill_d;
    logic [23:0] ext_d;
    logic [15:0] mem_rd;
    logic [3:0] raddr_lo;

    always_comb begin
        bank_d = bank_q;
        wp_d = wp_q;
        n_d = n_q;
        rd_bank_d = rd_bank_q;
        rd_start_d = rd_start_q;
        rd_cnt_d = rd_cnt_q;
        open_acc_d = open_acc_q;
        inv_acc_d = inv_acc_q;
        open_d = open_q;
        inv_d = inv_q;
        fill_d = fill_q;
        ext_d = ext_value_q;
        mem_we = pop && multi;
        if (pop && multi) begin
            wp_d = (wp_q == 4'(SLOTS - 1)) ? 4'h0 : wp_q + 4'h1;
            n_d = (n_q == 5'h1f) ? n_q : n_q + 5'h01;
            open_acc_d = open_acc_q || ff_out.open;
            inv_acc_d = inv_acc_q || ff_out.invalid;
        end
        if (bus_cycle_start && multi) begin
            rd_bank_d = bank_q;
            // past ten samples the oldest live one sits at the write pointer
            rd_start_d = (n_q >= 5'(SLOTS)) ? wp_q : 4'h0;
            rd_cnt_d = (n_q >= 5'(SLOTS)) ? 4'(SLOTS) : n_q[3:0];
            bank_d = !bank_q;
            wp_d = 4'h0;
            n_d = 5'h00;
            open_d = open_acc_q; // open bridge in any sample of the cycle
            inv_d = inv_acc_q;
            open_acc_d = 1'b0;
            inv_acc_d = 1'b0;
        end
        if (pop && !multi) begin
            open_d = ff_out.open;
            inv_d = ff_out.invalid;
            fill_d = (fill_q == 5'(FIR_FILL)) ? fill_q : fill_q + 5'h01;
            ext_d = (ff_out.invalid || rate_bad || supply_bad) ?
                VALUE_INVALID : ff_out.raw;
        end
        if (supply_bad || !fir_on || multi) begin
            fill_d = 5'h00;
        end
        if ((supply_bad || rate_bad) && !multi) begin
            ext_d = VALUE_INVALID;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bank_q <= 1'b0;
            wp_q <= 4'h0;
            n_q <= 5'h00;
            rd_bank_q <= 1'b1;
            rd_start_q <= 4'h0;
            rd_cnt_q <= 4'h0;
            open_acc_q <= 1'b0;
            inv_acc_q <= 1'b0;
            open_q <= 1'b0;
            inv_q <= 1'b0;
            fill_q <= 5'h00;
            ext_value_q <= VALUE_INVALID;
        end else begin
            bank_q <= bank_d;
            wp_q <= wp_d;
            n_q <= n_d;
            rd_bank_q <= rd_bank_d;
            rd_start_q <= rd_start_d;
            rd_cnt_q <= rd_cnt_d;
            open_acc_q <= open_acc_d;
            inv_acc_q <= inv_acc_d;
            open_q <= open_d;
            inv_q <= inv_d;
            fill_q <= fill_d;
            ext_value_q <= ext_d;
        end
    end

    assign sum = {1'b0, rd_start_q} + {1'b0, slot_sel};
    assign raddr_lo = (sum >= 5'(SLOTS)) ? 4'(sum - 5'(SLOTS)) : sum[3:0];

    sgf_mem #(.W(16), .N(32)) u_mem (
        .clk(clk),
        .we(mem_we),
        .waddr({bank_q, wp_q}),
        .wdata(ff_out.raw[23:8]),
        .raddr({rd_bank_q, raddr_lo}),
        .rdata_q(mem_rd)
    );

    // outputs: slot read pipeline, status and filter setup
    logic slot_inv_q, slot_inv_d;
    logic [15:0] slot_d;
    logic [7:0] health_d;
    logic [3:0] iir_d;
    logic [16:0] rate_d;

    always_comb begin
        slot_inv_d = nosync_q || !multi || (slot_sel >= rd_cnt_q);
        slot_d = slot_inv_q ? SLOT_INVALID : mem_rd;
        health_d = HEALTH_RST;
        health_d[ST_OPEN] = open_q;
        if (multi) begin
            health_d[ST_INVALID] = inv_q;
            health_d[ST_NOSYNC] = nosync_q;
        end else begin
            health_d[ST_INVALID] = inv_q || rate_bad || supply_bad;
            health_d[ST_MOD_SUP] = module_supply_fault;
            health_d[ST_EXC_SUP] = excite_supply_fault;
            health_d[ST_FIR_BUSY] = fir_on && (fill_q != 5'(FIR_FILL));
        end
        // undefined levels above eight fall back to bypass
        iir_d = (cfg.filter_and_range_config[3:0] > IIR_MAX) ?
            4'h0 : cfg.filter_and_range_config[3:0];
        rate_d = fine ? {1'b0, cfg.fine_step_output_rate} :
            coded_tenths(cfg.coded_output_rate[3:0]);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            slot_inv_q <= 1'b1;
            slot_data_q <= SLOT_INVALID;
            health_q <= HEALTH_RST;
            iir_level_q <= 4'h0;
            range_q <= 3'h0;
            fir_en_q <= 1'b0;
            fir_rate_q <= 17'h0;
            filter_clear_q <= 1'b1;
        end else begin
            slot_inv_q <= slot_inv_d;
            slot_data_q <= slot_d;
            health_q <= health_d;
            iir_level_q <= iir_d;
            range_q <= cfg.filter_and_range_config[6:4];
            fir_en_q <= fir_on;
            fir_rate_q <= rate_d;
            filter_clear_q <= supply_bad;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_conv_pulse;
        conv_start_q ##1 !conv_start_q;
    endsequence

    a_sync_flag_set: assert property (bus_cycle_start && multi && conv_cnt_q != 15'h0
        |=> ##1 health_q[ST_NOSYNC] || !multi) else $error("lost lock not flagged");
    a_sync_bit_clear: assert property (bus_cycle_start && multi && conv_cnt_q == 15'h0
        |=> ##1 !health_q[ST_NOSYNC]) else $error("lock wrongly flagged");
    a_slot_nosync: assert property (nosync_q |-> ##2 slot_data_q == SLOT_INVALID)
        else $error("slot not invalid without lock");
    a_slot_beyond: assert property (slot_sel >= rd_cnt_q |-> ##2 slot_data_q == SLOT_INVALID)
        else $error("unfilled slot returned data");
    a_conv_spacing: assert property (s_conv_pulse |-> (!conv_start_q)[*8])
        else $error("converter start too close");
    a_rate_code_bad: assert property (!multi && rate_bad |=> health_q[ST_INVALID])
        else $error("bad rate code not reported");
    a_iir_bypass: assert property (cfg.filter_and_range_config[3:0] == 4'h0
        |=> iir_level_q == 4'h0) else $error("iir not bypassed");
    a_fine_disable: assert property (fine && cfg.fine_step_output_rate == 16'h0
        |=> !fir_en_q) else $error("fir not disabled");
    a_supply_clear: assert property (supply_bad && !multi
        |=> filter_clear_q && health_q[ST_INVALID] && ext_value_q == VALUE_INVALID)
        else $error("supply fault not handled");
    a_supply_bits: assert property (!multi |=> health_q[ST_MOD_SUP]
        == $past(module_supply_fault) && health_q[ST_EXC_SUP] == $past(excite_supply_fault))
        else $error("supply bits wrong");
    a_stamp_capture: assert property (push |=> stamp_q == $past(us_cnt_q))
        else $error("timestamp not captured");
    a_rsvd_zero: assert property (health_q[7:6] == 2'b00 and (!multi |=> !health_q[ST_NOSYNC]))
        else $error("reserved status bit set");
endmodule
`default_nettype wire

// File: verif/sgf_bus_model.sv
// bus master model: marks each bus cycle with a one-cycle start pulse
// assumes the bench clock; drives on the falling edge, period in cycles
`timescale 1ns/1ps
`default_nettype none
module sgf_bus_model #(
    parameter int MIN_CYC = 100
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [15:0] period,
    output logic bus_cycle_start
);
    int cnt = 0;
    int per;
    initial bus_cycle_start = 1'b0;
    // a shorter request is stretched, never run below the minimum cycle
    always @(negedge clk) begin
        per = (int'(period) < MIN_CYC) ? MIN_CYC : int'(period);
        if (sys_rst || cnt >= per - 1) begin
            cnt = 0;
        end else begin
            cnt = cnt + 1;
        end
        bus_cycle_start = !sys_rst && cnt == 0;
    end
endmodule
`default_nettype wire

// File: verif/sgf_ctrl_test.sv
// self-checking bench for the bridge converter control block
// assumes shortened converter cycles (20/40 clocks, i.e. 0.4 clock per us)
`timescale 1ns/1ps
`default_nettype none
module sgf_ctrl_test;
    import sgf_pkg::*;
    logic clk, sys_rst, bus_cycle_start, conv_valid, conv_ready, took;
    logic module_supply_fault, excite_supply_fault, conv_start_q, fir_en_q;
    logic filter_clear_q, s_open, s_inv;
    sgf_model_t model_sel;
    sgf_cfg_t cfg;
    sgf_sample_t conv_sample;
    logic [3:0] slot_sel, iir_level_q;
    logic [15:0] slot_data_q, bus_period, seq, last;
    logic [7:0] health_q;
    logic [31:0] stamp_q, s0;
    logic [2:0] range_q;
    logic [16:0] fir_rate_q;
    logic [23:0] ext_value_q;
    int num_errors, checked, want_n, cycles, gap;
    int rate_tbl [14] = '{25, 50, 100, 150, 250, 300, 500, 600, 1000, 5000, 10000,
        20000, 37500, 75000};
    logic [15:0] per_tbl [4] = '{16'd160, 16'd320, 16'd120, 16'd160};
    logic [7:0] cyc_tbl [4] = '{8'h00, 8'h00, 8'h01, 8'h01};
    int cnt_tbl [4] = '{8, 10, 3, 4};
    logic [15:0] fine_tbl [4] = '{16'h0001, 16'hffff, 16'h0000, 16'h002a};

    sgf_ctrl #(.SHORT_CYC(20), .LONG_CYC(40)) DUT (.clk(clk), .sys_rst(sys_rst),
        .bus_cycle_start(bus_cycle_start), .model_sel(model_sel), .cfg(cfg),
        .conv_sample(conv_sample), .conv_valid(conv_valid), .conv_ready(conv_ready),
        .module_supply_fault(module_supply_fault), .excite_supply_fault(excite_supply_fault),
        .slot_sel(slot_sel), .slot_data_q(slot_data_q), .health_q(health_q),
        .stamp_q(stamp_q), .conv_start_q(conv_start_q), .iir_level_q(iir_level_q),
        .range_q(range_q), .fir_en_q(fir_en_q), .fir_rate_q(fir_rate_q),
        .filter_clear_q(filter_clear_q), .ext_value_q(ext_value_q));
    sgf_bus_model #(.MIN_CYC(100)) master (.clk(clk), .sys_rst(sys_rst),
        .period(bus_period), .bus_cycle_start(bus_cycle_start));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // converter stand-in: one sample per start pulse or per bench request;
    // the low byte is a fixed 0x5a so a slot that keeps it shows wrong truncation
    always @(posedge clk) took <= conv_valid & conv_ready;
    always @(negedge clk) begin
        if (conv_start_q === 1'b1) want_n = want_n + 1;
        if (took) begin
            conv_valid = 1'b0;
            seq = seq + 16'h1;
        end else if (!conv_valid && want_n > 0) begin
            conv_sample = '{open: s_open, invalid: s_inv, raw: {seq, 8'h5a}};
            conv_valid = 1'b1;
            want_n = want_n - 1;
        end
    end

    // hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ask the converter for n samples and wait until all were taken
    task automatic push_n(input int n);
        @(posedge clk);
        want_n = want_n + n;
        for (int i = 0; i < 400 && (want_n > 0 || conv_valid); i++) @(posedge clk);
        if (want_n > 0 || conv_valid) num_errors = num_errors + 1;
        tick(3);
    endtask

    // find the next bus cycle start and note the newest sample taken before it
    task automatic wait_start();
        int k;
        k = 0;
        @(posedge clk);
        while (bus_cycle_start !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k = k + 1;
        end
        if (k >= 2000) num_errors = num_errors + 1;
        last = seq - 16'h1;
        tick(1);
    endtask

    // slots hold the newest n samples, oldest first; the rest are invalid
    task automatic chk_slots(input int n);
        logic [15:0] v;
        for (int i = 0; i < 10; i++) begin
            slot_sel = i[3:0];
            tick(3);
            v = slot_data_q;
            chk(v, (i < n) ? 16'(int'(last) - n + 1 + i) : SLOT_INVALID);
        end
    endtask

    initial begin
        sys_rst = 1'b1;
        model_sel = SGF_MULTI;
        cfg = '0;
        conv_valid = 1'b0;
        conv_sample = '0;
        took = 1'b0;
        module_supply_fault = 1'b0;
        excite_supply_fault = 1'b0;
        slot_sel = 4'h0;
        bus_period = 16'd160;
        s_open = 1'b0;
        s_inv = 1'b0;
        seq = 16'h0000;
        want_n = 0;
        num_errors = 0;
        checked = 0;
        cycles = 0;
        tick(3);
        chk(slot_data_q, SLOT_INVALID);
        chk(health_q, HEALTH_RST);
        chk(ext_value_q, VALUE_INVALID);
        chk(conv_ready, 1'b1);
        tick(3);
        sys_rst = 1'b0;
        // multisampling: counts per bus and converter cycle, newest kept
        for (int t = 0; t < 4; t++) begin
            bus_period = per_tbl[t];
            cfg.converter_cycle_select = cyc_tbl[t];
            repeat (3) wait_start();
            chk_slots(cnt_tbl[t]);
            chk(health_q, 8'h00);
            // locked converter starts sit exactly one converter cycle apart
            while (conv_start_q !== 1'b1) tick(1);
            gap = 0;
            do begin
                tick(1);
                gap = gap + 1;
            end while (conv_start_q !== 1'b1 && gap < 100);
            chk(gap, (cyc_tbl[t] == CYC_LONG) ? 40 : 20);
        end
        bus_period = 16'd170;
        cfg.converter_cycle_select = 8'h00;
        repeat (3) wait_start();
        chk_slots(0);
        chk(health_q[2], 1'b1);
        $display("multisample test done");
        // extended filter: level and range codes
        bus_period = 16'd160;
        model_sel = SGF_EXT;
        for (int c = 0; c < 16; c++) begin
            cfg.filter_and_range_config = {1'b0, c[2:0], c[3:0]};
            tick(3);
            chk(iir_level_q, (c <= 8) ? c : 0);
            chk(range_q, c[2:0]);
        end
        cfg.fine_step_output_rate = 16'h1234;
        for (int c = 0; c < 16; c++) begin
            cfg.coded_output_rate = {4'h0, c[3:0]};
            tick(3);
            chk(fir_rate_q, (c < 14) ? rate_tbl[c] : 0);
            if (c >= 14) chk(ext_value_q, VALUE_INVALID);
            if (c >= 14) chk(health_q[0], 1'b1);
        end
        cfg.rate_mode_select = RATE_FINE;
        for (int k = 0; k < 4; k++) begin
            cfg.fine_step_output_rate = fine_tbl[k];
            tick(3);
            chk(fir_rate_q, fine_tbl[k]);
            chk(fir_en_q, fine_tbl[k] != 16'h0000);
        end
        cfg.rate_mode_select = 16'h0000;
        cfg.coded_output_rate = 8'h00;
        tick(3);
        chk(fir_rate_q, 25);
        $display("filter config test done");
        // status flags follow the latest sample
        s_open = 1'b1;
        push_n(1);
        chk(health_q[1], 1'b1);
        s_open = 1'b0;
        push_n(1);
        chk(health_q[1], 1'b0);
        s_inv = 1'b1;
        push_n(1);
        chk(health_q[0], 1'b1);
        s_inv = 1'b0;
        // two conversions exactly 500 clocks (2 us) apart
        @(posedge clk);
        want_n = want_n + 1;
        repeat (10) @(negedge clk);
        s0 = stamp_q;
        repeat (491) @(posedge clk);
        want_n = want_n + 1;
        tick(10);
        chk(stamp_q - s0, 32'd2);
        // supply faults, then refill of the fir history
        for (int f = 0; f < 2; f++) begin
            module_supply_fault = (f == 0);
            excite_supply_fault = (f == 1);
            tick(3);
            chk(health_q[4:3], (f == 0) ? 2'b01 : 2'b10);
            chk(filter_clear_q, 1'b1);
            chk(ext_value_q, VALUE_INVALID);
        end
        excite_supply_fault = 1'b0;
        push_n(FIR_FILL - 1);
        chk(health_q[5], 1'b1);
        push_n(1);
        chk(health_q, 8'h00);
        chk(filter_clear_q, 1'b0);
        $display("status test done");
        end_sim();
    end
endmodule
`default_nettype wire
